// file: design/sleep_pkg.sv
// Constants for the processor sleep and wake-up controller.
// Assumes a single 50 MHz system clock and synchronous reset.
package sleep_pkg;
    localparam int unsigned CLK_HZ = 50_000_000;

    // Avalon-MM register map, byte addresses
    localparam logic [3:0] ADDR_SYSTEM_CONTROL_REG = 4'h0;
    localparam logic [3:0] ADDR_STATUS  = 4'h4;
    localparam logic [3:0] ADDR_MASKS   = 4'h8;
    localparam logic [3:0] ADDR_TIMING  = 4'hC;

    // system_control_reg fields
    localparam int unsigned SLEEP_ON_EXIT_BIT  = 1;
    localparam int unsigned DEEP_SLEEP_BIT     = 2;
    localparam int unsigned PEND_WAKES_EVT_BIT = 4;
    localparam logic [31:0] SYSTEM_CONTROL_REG_RESET      = 32'h0000_0000;
    localparam logic [31:0] SYSTEM_CONTROL_REG_WMASK      = 32'h0000_0016;

    // Mask register fields
    localparam int unsigned INT_MASK_BIT = 0;
    localparam int unsigned ESC_MASK_BIT = 1;

    // Status register fields
    localparam int unsigned ST_LIGHT_BIT   = 0;
    localparam int unsigned ST_DEEP_BIT    = 1;
    localparam int unsigned ST_BY_WFE_BIT  = 2;
    localparam int unsigned ST_RESTORE_BIT = 3;
    localparam int unsigned ST_WAKES_LSB   = 8;

    // Deep-sleep restore time
    localparam int unsigned RESTORE_US     = 10;
    localparam int unsigned RESTORE_CYCLES = (RESTORE_US * (CLK_HZ / 1_000_000));
    localparam int unsigned RESTORE_W      = 16;

    typedef enum logic [2:0] {
        ST_RUN,
        ST_LIGHT,
        ST_DEEP,
        ST_RESTORE
    } sleep_state_e;
endpackage

// file: design/sleep_wake_ctrl.sv
// Sleep and wake-up controller: decides light/deep sleep entry and exit.
// Assumes the core pipeline pulses instruction strobes and the interrupt
// controller gives level wake conditions, all on CLK.
// Operation
// R1 - Light sleep gates the core clock, system clock keeps running.
// R2 - Deep sleep stops system clock, powers off PLL and flash.
// R3 - deep_sleep_select bit chooses light or deep sleep.
// R4 - wait_interrupt_op sleeps at once unless a wake condition already holds.
// R5 - wait_event_op with event latch 0 stops execution and sleeps.
// R6 - wait_event_op with latch 1 clears it and continues.
// R7 - send_event_op sets the event latch.
// R8 - Software has no register path to the event latch.
// R9 - sleep_on_exit_enable sleeps after the last handler returns.
// R10 - Interrupt or exit sleep wakes only on an entry-worthy exception.
// R11 - Masked interrupt of higher priority wakes; entry waits for unmask.
// R12 - Event sleep wakes on an entry-worthy exception.
// R13 - pending_wakes_event makes each new pending interrupt wake event sleep.
// R14 - Spurious wakes, like debug, are allowed; software resleeps.
// R15 - Deep wake restores clock, PLL and flash before fetch resumes.
//
// The Avalon-MM register port and the register offsets were decided locally.
module sleep_wake_ctrl #(
    parameter int unsigned RESTORE_COUNT = sleep_pkg::RESTORE_CYCLES
) (
    // Clock and synchronous reset
    input  wire logic        CLK,
    input  wire logic        RST,

    // Avalon-MM register port
    input  wire logic [3:0]  AVS_ADDRESS,
    input  wire logic        AVS_READ,
    input  wire logic        AVS_WRITE,
    input  wire logic [31:0] AVS_WRITEDATA,
    input  wire logic [3:0]  AVS_BYTEENABLE,
    output logic [31:0]      AVS_READDATA,
    output logic             AVS_WAITREQUEST,

    // Core pipeline strobes, one cycle each
    input  wire logic        WAIT_INTERRUPT_OP,
    input  wire logic        WAIT_EVENT_OP,
    input  wire logic        SEND_EVENT_OP,
    input  wire logic        LAST_HANDLER_EXIT,

    // Interrupt controller wake conditions
    input  wire logic        EXC_ENTRY_READY,
    input  wire logic        IRQ_ENABLED_HIGHER,
    input  wire logic        NEW_PENDING_IRQ,
    input  wire logic        DEBUG_WAKE,

    // Clock, power and core controls
    output logic             CORE_HALT,
    output logic             CORE_CLK_EN,
    output logic             SYS_CLK_EN,
    output logic             PLL_PWR_EN,
    output logic             FLASH_PWR_EN,
    output logic             HANDLER_ENTRY_OK,
    output logic             EVENT_LATCH
);
    import sleep_pkg::*;

    typedef struct packed {
        // Sleep machine, event latch, software state
        sleep_state_e          state;
        logic                  by_wfe;
        logic                  evt;
        logic [31:0]           system_control_reg;
        logic [1:0]            masks;
        logic [RESTORE_W-1:0]  cnt;
        logic [7:0]            wakes;
        // Bus answer
        logic                  ack;
        logic                  waitreq;
        logic [31:0]           rdata;
        // Registered outputs
        logic                  halt;
        logic                  core_clk;
        logic                  sys_clk;
        logic                  pll;
        logic                  flash;
        logic                  entry_ok;
    } regs_s;

    regs_s q;
    regs_s d;

    // Decoded configuration and wake terms
    logic        deep_sel;
    logic        int_mask;
    logic        esc_mask;
    logic        pend_evt_en;
    logic        pend_evt;
    logic        irq_wake;
    logic        evt_wake;
    // Sleep machine steps
    logic        wfi_enter;
    logic        wfe_skip;
    logic        wfe_enter;
    logic        exit_enter;
    logic        go_sleep;
    logic        wake;
    logic        restore_done;
    // Bus decode
    logic        req;
    logic        acc;
    logic        wr_take;
    logic        rd_acc;
    logic [31:0] wmask;
    logic [31:0] status;

    always_comb begin
        d = q;

        // Configuration and mask bits in use
        deep_sel    = q.system_control_reg[DEEP_SLEEP_BIT];
        pend_evt_en = q.system_control_reg[PEND_WAKES_EVT_BIT];
        int_mask    = q.masks[INT_MASK_BIT];
        esc_mask    = q.masks[ESC_MASK_BIT];

        // R11 masked interrupt wakes
        irq_wake = EXC_ENTRY_READY || (int_mask && !esc_mask && IRQ_ENABLED_HIGHER);
        // R13 pending event wake
        pend_evt = pend_evt_en && NEW_PENDING_IRQ;
        evt_wake = irq_wake || pend_evt;

        // Entry requests, acted on only while running
        wfi_enter  = WAIT_INTERRUPT_OP && !irq_wake;
        wfe_skip   = WAIT_EVENT_OP && q.evt;
        wfe_enter  = WAIT_EVENT_OP && !q.evt && !evt_wake;
        exit_enter = q.system_control_reg[SLEEP_ON_EXIT_BIT] && LAST_HANDLER_EXIT && !irq_wake;
        go_sleep   = 1'b0;
        wake       = 1'b0;
        // Counter end, held against the parameter
        restore_done = (q.cnt >= RESTORE_W'(RESTORE_COUNT - 1));

        // R8 latch has no bus path; R7 send sets latch
        if (SEND_EVENT_OP || pend_evt) begin
            d.evt = 1'b1;
        end

        unique case (q.state)
            ST_RUN: begin
                // R4 wait-interrupt entry
                if (wfi_enter) begin
                    go_sleep = 1'b1;
                    d.by_wfe = 1'b0;
                end else if (wfe_skip) begin
                    // R6 consume latch; only a send event in the same cycle keeps it set
                    d.evt = SEND_EVENT_OP;
                end else if (wfe_enter) begin
                    // R5 event sleep entry
                    go_sleep = 1'b1;
                    d.by_wfe = 1'b1;
                end else if (exit_enter) begin
                    // R9 sleep after last handler
                    go_sleep = 1'b1;
                    d.by_wfe = 1'b0;
                end
                // Every entry path lands here
                if (go_sleep) begin
                    // R3 mode select
                    if (deep_sel) begin
                        d.state = ST_DEEP;
                    end else begin
                        d.state = ST_LIGHT;
                    end
                end
            end

            ST_LIGHT, ST_DEEP: begin
                // R10 R12 wake conditions
                if (q.by_wfe) begin
                    wake = evt_wake;
                end else begin
                    wake = irq_wake;
                end
                // R14 spurious debug wake
                if (DEBUG_WAKE) begin
                    wake = 1'b1;
                end
                // Pending event that ends event sleep is used up
                if (q.by_wfe && pend_evt && !irq_wake) begin
                    d.evt = 1'b0;
                end
                if (wake) begin
                    d.wakes = q.wakes + 8'h01;
                    if (q.state == ST_DEEP) begin
                        d.state = ST_RESTORE;
                        d.cnt   = '0;
                    end else begin
                        d.state = ST_RUN;
                    end
                end
            end

            ST_RESTORE: begin
                // R15 hold core until restored
                if (restore_done) begin
                    d.state = ST_RUN;
                    d.cnt   = '0;
                end else begin
                    d.cnt = q.cnt + RESTORE_W'(1);
                end
            end

            // Only reachable by an upset of the state bits
            default: begin
                d.state = ST_RUN;
            end
        endcase

        // Outputs follow the next state, so they flip with it
        d.halt     = 1'b1;
        d.core_clk = 1'b0;
        d.sys_clk  = 1'b1;
        d.pll      = 1'b1;
        d.flash    = 1'b1;
        d.entry_ok = 1'b0;
        unique case (d.state)
            ST_RUN: begin
                d.halt     = 1'b0;
                // R1 core clock runs only in run
                d.core_clk = 1'b1;
                // R11 handler entry waits for unmask
                d.entry_ok = !int_mask;
            end

            ST_LIGHT: begin
                // R1 light sleep keeps system clock
                d.sys_clk  = 1'b1;
            end

            ST_DEEP: begin
                // R2 deep sleep stops clock, PLL, flash
                d.sys_clk  = 1'b0;
                d.pll      = 1'b0;
                d.flash    = 1'b0;
            end

            ST_RESTORE: begin
                // R15 power back on, core still held
                d.sys_clk  = 1'b1;
            end

            default: begin
                d.halt     = 1'b1;
            end
        endcase

        // Avalon slave: waitrequest idles high, drops for one answering cycle
        req       = AVS_READ || AVS_WRITE;
        acc       = req && !q.ack;
        wr_take   = AVS_WRITE && q.ack;
        rd_acc    = acc && AVS_READ;
        d.ack     = acc;
        d.waitreq = !acc;

        // Byte lanes to bit mask
        for (int b = 0; b < 4; b++) begin
            wmask[8*b +: 8] = {8{AVS_BYTEENABLE[b]}};
        end

        // Status view of the sleep machine
        status                     = 32'h0000_0000;
        status[ST_LIGHT_BIT]       = (q.state == ST_LIGHT);
        status[ST_DEEP_BIT]        = (q.state == ST_DEEP);
        status[ST_BY_WFE_BIT]      = q.by_wfe;
        status[ST_RESTORE_BIT]     = (q.state == ST_RESTORE);
        status[ST_WAKES_LSB +: 8]  = q.wakes;

        // Write lands on the edge that sees waitrequest low
        if (wr_take) begin
            unique case (AVS_ADDRESS)
                ADDR_SYSTEM_CONTROL_REG: begin
                    d.system_control_reg = (q.system_control_reg & ~(wmask & SYSTEM_CONTROL_REG_WMASK))
                              | (AVS_WRITEDATA & wmask & SYSTEM_CONTROL_REG_WMASK);
                end
                ADDR_MASKS: begin
                    if (AVS_BYTEENABLE[0]) begin
                        d.masks = AVS_WRITEDATA[1:0];
                    end
                end
                // Status, timing and holes ignore writes
                default: begin
                end
            endcase
        end

        // Read data stand only in the answering cycle
        d.rdata = 32'h0000_0000;
        if (rd_acc) begin
            unique case (AVS_ADDRESS)
                ADDR_SYSTEM_CONTROL_REG: begin
                    d.rdata = q.system_control_reg;
                end
                ADDR_STATUS: begin
                    d.rdata = status;
                end
                ADDR_MASKS: begin
                    d.rdata = {30'h0, q.masks};
                end
                ADDR_TIMING: begin
                    d.rdata = 32'(RESTORE_COUNT);
                end
                default: begin
                    d.rdata = 32'h0000_0000;
                end
            endcase
        end
    end

    // Synchronous reset; no clock enable anywhere
    always_ff @(posedge CLK) begin
        if (RST) begin
            // Running, clocks and power on, bus idle
            q          <= '0;
            q.state    <= ST_RUN;
            q.by_wfe   <= 1'b0;
            q.evt      <= 1'b0;
            q.system_control_reg  <= SYSTEM_CONTROL_REG_RESET;
            q.masks    <= 2'h0;
            q.cnt      <= '0;
            q.wakes    <= 8'h00;
            q.ack      <= 1'b0;
            q.waitreq  <= 1'b1;
            q.rdata    <= 32'h0000_0000;
            q.halt     <= 1'b0;
            q.core_clk <= 1'b1;
            q.sys_clk  <= 1'b1;
            q.pll      <= 1'b1;
            q.flash    <= 1'b1;
            q.entry_ok <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // Every output straight from its register
    assign AVS_READDATA     = q.rdata;
    assign AVS_WAITREQUEST  = q.waitreq;
    assign CORE_HALT        = q.halt;
    assign CORE_CLK_EN      = q.core_clk;
    assign SYS_CLK_EN       = q.sys_clk;
    assign PLL_PWR_EN       = q.pll;
    assign FLASH_PWR_EN     = q.flash;
    assign HANDLER_ENTRY_OK = q.entry_ok;
    assign EVENT_LATCH      = q.evt;
endmodule

// file: test/sleep_sva.sv
// Port checker for the sleep and wake-up controller.
// Assumes one clock CLK and synchronous reset RST.
module sleep_sva #(parameter int unsigned RESTORE_COUNT = 4) (
    input wire logic CLK, RST, WAIT_INTERRUPT_OP, WAIT_EVENT_OP, SEND_EVENT_OP,
    input wire logic EXC_ENTRY_READY, IRQ_ENABLED_HIGHER, NEW_PENDING_IRQ, DEBUG_WAKE,
    input wire logic CORE_HALT, CORE_CLK_EN, SYS_CLK_EN, PLL_PWR_EN, FLASH_PWR_EN, EVENT_LATCH
);
    localparam int WAKE_MAX = RESTORE_COUNT + 8;
    wire logic quiet = !EXC_ENTRY_READY && !IRQ_ENABLED_HIGHER && !NEW_PENDING_IRQ && !DEBUG_WAKE;
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    sequence ran(logic op); op && !CORE_HALT && quiet; endsequence
    sequence restoring; CORE_HALT && SYS_CLK_EN && PLL_PWR_EN && FLASH_PWR_EN; endsequence
    chk_light_clock: assert property (CORE_CLK_EN |-> !CORE_HALT && SYS_CLK_EN)
        else $error("core clock runs while halted");
    chk_deep_power: assert property (!SYS_CLK_EN |-> CORE_HALT && !PLL_PWR_EN && !FLASH_PWR_EN)
        else $error("deep sleep left power on");
    chk_wfi_sleep: assert property (ran(WAIT_INTERRUPT_OP) |-> ##[1:2] CORE_HALT)
        else $error("wait interrupt did not sleep");
    chk_wfi_awake: assert property (WAIT_INTERRUPT_OP && !CORE_HALT && EXC_ENTRY_READY |=> !CORE_HALT [*2])
        else $error("slept with wake pending");
    chk_wfe_sleep: assert property (ran(WAIT_EVENT_OP && !EVENT_LATCH && !SEND_EVENT_OP) |-> ##[1:2] CORE_HALT)
        else $error("wait event did not sleep");
    chk_wfe_skip: assert property (WAIT_EVENT_OP && EVENT_LATCH && !SEND_EVENT_OP && !CORE_HALT
        |=> !EVENT_LATCH && !CORE_HALT ##1 !CORE_HALT) else $error("set latch not consumed");
    chk_event_set: assert property (SEND_EVENT_OP && !CORE_HALT |=> EVENT_LATCH)
        else $error("send event left latch clear");
    chk_exc_wake: assert property (CORE_HALT && EXC_ENTRY_READY |-> ##[1:WAKE_MAX] !CORE_HALT)
        else $error("exception did not wake");
    chk_deep_restore: assert property ($rose(SYS_CLK_EN) |-> restoring ##1 CORE_HALT [*3])
        else $error("fetch resumed before restore");
endmodule
bind sleep_wake_ctrl sleep_sva #(.RESTORE_COUNT(RESTORE_COUNT)) u_sva (.CLK(CLK), .RST(RST),
    .WAIT_INTERRUPT_OP(WAIT_INTERRUPT_OP), .WAIT_EVENT_OP(WAIT_EVENT_OP), .SEND_EVENT_OP(SEND_EVENT_OP),
    .EXC_ENTRY_READY(EXC_ENTRY_READY), .IRQ_ENABLED_HIGHER(IRQ_ENABLED_HIGHER),
    .NEW_PENDING_IRQ(NEW_PENDING_IRQ), .DEBUG_WAKE(DEBUG_WAKE), .CORE_HALT(CORE_HALT),
    .CORE_CLK_EN(CORE_CLK_EN), .SYS_CLK_EN(SYS_CLK_EN), .PLL_PWR_EN(PLL_PWR_EN),
    .FLASH_PWR_EN(FLASH_PWR_EN), .EVENT_LATCH(EVENT_LATCH));

// file: test/core_model.sv
// Core pipeline stand-in: op codes become one-cycle strobes.
// Assumes op changes right after a rising CLK edge.
module core_model (
    input  wire logic       CLK,
    input  wire logic       halted,
    input  wire logic [2:0] op,
    output logic            wait_interrupt_op,
    output logic            wait_event_op,
    output logic            send_event_op,
    output logic            handler_exit
);
    // A halted core issues nothing
    always_ff @(posedge CLK) begin
        {handler_exit, send_event_op, wait_event_op, wait_interrupt_op} <= (halted || op > 3'h3) ? 4'h0 : 4'h1 << op;
    end
endmodule

// file: test/testbench.sv
// Self-checking bench for the sleep and wake-up controller.
// Assumes core_model and the bound checker are compiled first.
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import sleep_pkg::*;
    logic CLK = 0, RST = 1, rd = 0, wr = 0, dp, halt, cclk, sclk, pll, fl, eok, lat, wi, we, se, lh, wq;
    logic [3:0] adr = 4'h0, src = 4'h0;
    logic [2:0] op = 3'h4;
    logic [31:0] wd = 32'h0, rdat, q;
    int miscompares = 0, checks_done = 0, n;
    sleep_wake_ctrl #(.RESTORE_COUNT(4)) i_dut (.CLK(CLK), .RST(RST), .AVS_ADDRESS(adr), .AVS_READ(rd),
        .AVS_WRITE(wr), .AVS_WRITEDATA(wd), .AVS_BYTEENABLE(4'hF), .AVS_READDATA(rdat), .AVS_WAITREQUEST(wq),
        .WAIT_INTERRUPT_OP(wi), .WAIT_EVENT_OP(we), .SEND_EVENT_OP(se), .LAST_HANDLER_EXIT(lh),
        .EXC_ENTRY_READY(src[0]), .IRQ_ENABLED_HIGHER(src[1]), .NEW_PENDING_IRQ(src[2]), .DEBUG_WAKE(src[3]),
        .CORE_HALT(halt), .CORE_CLK_EN(cclk), .SYS_CLK_EN(sclk), .PLL_PWR_EN(pll), .FLASH_PWR_EN(fl),
        .HANDLER_ENTRY_OK(eok), .EVENT_LATCH(lat));
    core_model u_core (.CLK(CLK), .halted(halt), .op(op), .wait_interrupt_op(wi), .wait_event_op(we), .send_event_op(se), .handler_exit(lh));
    initial begin
        forever #10 CLK = ~CLK;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        wr <= w;
        rd <= !w;
        adr <= a;
        wd <= d;
        do @(posedge CLK); while (wq !== 1'b0);
        q = rdat;
        wr <= 1'b0;
        rd <= 1'b0;
        @(posedge CLK);
    endtask
    task automatic issue(input logic [2:0] k);
        op <= k;
        @(posedge CLK);
        op <= 3'h4;
        repeat (5) @(posedge CLK);
    endtask
    task automatic wake(input int s);
        src <= 4'h1 << s;
        @(posedge CLK);
        src <= 4'h0;
        for (n = 0; n < 30 && halt !== 1'b0; n++) @(posedge CLK);
        repeat (2) @(posedge CLK);
    endtask
    // Halt, core clock, system clock and PLL while asleep
    function automatic logic [3:0] asleep(input logic deep);
        return {1'b1, 1'b0, !deep, !deep};
    endfunction
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        void'($urandom(81));
        repeat (5) @(posedge CLK);
        RST <= 1'b0;
        @(posedge CLK);
        bus(0, ADDR_SYSTEM_CONTROL_REG, 0);
        chk(q, SYSTEM_CONTROL_REG_RESET);
        // Unmapped and read-only places included
        for (int a = 0; a < 16; a += 2) bus(1, 4'(a), 32'hFFFF_FFFF);
        chk(lat, 1'b0);
        bus(0, 4'h2, 0);
        chk(q, 32'h0);
        bus(0, ADDR_SYSTEM_CONTROL_REG, 0);
        chk(q, SYSTEM_CONTROL_REG_WMASK);
        bus(1, ADDR_MASKS, 0);
        bus(0, ADDR_TIMING, 0);
        chk(q, 32'h4);
        $display("test registers done");
        for (int i = 0; i < 6; i++) begin
            dp = (i == 0) ? 1'b1 : (i == 1) ? 1'b0 : 1'($urandom % 2);
            bus(1, ADDR_SYSTEM_CONTROL_REG, 32'(dp) << DEEP_SLEEP_BIT);
            issue(3'h0);
            chk({halt, cclk, sclk, pll}, asleep(dp));
            chk(fl, !dp);
            bus(0, ADDR_STATUS, 0);
            chk(q[1:0], {dp, !dp});
            chk(q[15:8], 8'(i));
            wake(0);
            chk({halt, cclk, sclk, pll, fl}, 5'h0F);
        end
        src <= 4'h1;
        issue(3'h0);
        src <= 4'h0;
        chk(halt, 1'b0);
        $display("test wait interrupt done");
        issue(3'h2);
        chk(lat, 1'b1);
        issue(3'h1);
        chk({lat, halt}, 2'h0);
        bus(1, ADDR_SYSTEM_CONTROL_REG, 32'h1 << PEND_WAKES_EVT_BIT);
        issue(3'h1);
        chk(halt, 1'b1);
        wake(2);
        chk(halt, 1'b0);
        $display("test wait event done");
        bus(1, ADDR_SYSTEM_CONTROL_REG, 32'h1 << SLEEP_ON_EXIT_BIT);
        issue(3'h3);
        chk(halt, 1'b1);
        wake(0);
        chk(halt, 1'b0);
        bus(1, ADDR_SYSTEM_CONTROL_REG, 0);
        bus(1, ADDR_MASKS, 32'h1 << INT_MASK_BIT);
        issue(3'h0);
        wake(1);
        chk({halt, eok}, 2'h0);
        bus(1, ADDR_MASKS, 0);
        @(posedge CLK);
        chk(eok, 1'b1);
        issue(3'h0);
        wake(3);
        chk(halt, 1'b0);
        $display("test wake sources done");
        issue(3'h2);
        bus(1, ADDR_SYSTEM_CONTROL_REG, 32'h1 << DEEP_SLEEP_BIT);
        issue(3'h0);
        RST <= 1'b1;
        repeat (2) @(posedge CLK);
        RST <= 1'b0;
        @(posedge CLK);
        chk({halt, cclk, sclk, pll, fl, eok, lat}, 7'h3E);
        bus(0, ADDR_SYSTEM_CONTROL_REG, 0);
        chk(q, SYSTEM_CONTROL_REG_RESET);
        $display("test reset done");
        end_of_test;
    end
    initial begin
        repeat (3000) @(posedge CLK);
        miscompares++;
        end_of_test;
    end
endmodule
